// ==== shared/sync_conv_pkg.sv ====
// Constants and types for the MIDI to DIN sync converter
`default_nettype none
package sync_conv_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned MIDI_BAUD = 31_250;
  localparam int unsigned BIT_CYCLES = CLK_HZ / MIDI_BAUD;
  localparam int unsigned HALF_BIT_CYCLES = BIT_CYCLES / 2;
  localparam int unsigned HOLDOFF_US = 2_000;
  localparam int unsigned HOLDOFF_CYCLES = HOLDOFF_US * CLK_PER_US;
  localparam int unsigned RESTART_US = 2_000;
  localparam int unsigned RESTART_CYCLES = RESTART_US * CLK_PER_US;
  localparam int unsigned INHIBIT_MS = 1_000;
  localparam int unsigned INHIBIT_CYCLES = INHIBIT_MS * (CLK_HZ / 1_000);
  localparam int unsigned PULSE_HIGH_US = 500;
  localparam int unsigned PULSE_HIGH_CYCLES = PULSE_HIGH_US * CLK_PER_US;
  localparam int unsigned PULSE_LOW_US = 500;
  localparam int unsigned PULSE_LOW_CYCLES = PULSE_LOW_US * CLK_PER_US;
  localparam int unsigned PULSES_PER_QUARTER = 24;
  localparam logic [7:0] MSG_CLOCK = 8'hF8;
  localparam logic [7:0] MSG_START = 8'hFA;
  localparam logic [7:0] MSG_CONTINUE = 8'hFB;
  localparam logic [7:0] MSG_STOP = 8'hFC;
  localparam logic [4:0] PIN_RESET = 5'h10;
  localparam int unsigned PIN_MIDI = 4;
  localparam int unsigned PIN_BUTTON = 3;
  localparam int unsigned PIN_DIR = 2;
  localparam int unsigned PIN_EXT_RUN = 1;
  localparam int unsigned PIN_EXT_CLK = 0;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } rx_state_type;
endpackage
`default_nettype wire

// ==== rtl/midi_to_din_sync_converter.sv ====
// MIDI real-time to DIN sync run gate and clock, merged with the internal tempo system
//
// Notes on behaviour
// - Sync clock pulses high then low, 24 per quarter
// - One sync pulse per MIDI Clock byte
// - Clocks without Start still pulse, inhibit, run low
// - Start or Continue raises run gate
// - Stop drops run gate
// - Run gate stays high for whole playback
// - First clock held off 2 ms after run rises
// - Any sync byte inhibits tempo oscillator
// - Inhibit releases about one second after last byte
// - Uninhibited tempo oscillator runs continuously in output mode
// - Button start halts oscillator, restarts after 2 ms
// - Each button press in output mode toggles internal run flip-flop
// - Seen run gate is OR of both sources in output mode
// - Socket clock is OR of both sources
// - Input mode: nothing drives socket, pins feed sequencer
// - Converter functions always active, no enable
`default_nettype none
module midi_to_din_sync_converter #(
  parameter int unsigned HOLDOFF_CYCLES = sync_conv_pkg::HOLDOFF_CYCLES,
  parameter int unsigned RESTART_CYCLES = sync_conv_pkg::RESTART_CYCLES,
  parameter int unsigned INHIBIT_CYCLES = sync_conv_pkg::INHIBIT_CYCLES,
  parameter int unsigned PULSE_HIGH_CYCLES = sync_conv_pkg::PULSE_HIGH_CYCLES,
  parameter int unsigned PULSE_LOW_CYCLES = sync_conv_pkg::PULSE_LOW_CYCLES,
  parameter int unsigned PEND_W = 4
) (
  input wire logic sys_clk, // System clock, 100 MHz
  input wire logic rst, // Asynchronous reset, active high
  input wire logic midi_rx, // MIDI serial input pin, idle high
  input wire logic start_button, // Front-panel start/stop button, high when pressed
  input wire logic dir_output, // Sync switch: high selects output, low input
  input wire logic [23:0] tempo_half_period, // Internal clock half period in cycles
  input wire logic ext_run_in, // Run/stop level read back from the socket pin
  input wire logic ext_clk_in, // Clock level read back from the socket pin
  output logic sock_run_o, // Run/stop driven onto socket
  output logic sock_run_oe, // Run/stop pin drive enable
  output logic sock_clk_o, // Clock driven onto socket
  output logic sock_clk_oe, // Clock pin drive enable
  output logic seq_run, // Run gate seen by the internal sequencer
  output logic seq_clk, // Clock seen by the internal sequencer
  output logic osc_inhibit, // Halts internal tempo oscillator
  output logic int_run // Internal run flip-flop state
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [4:0] pin_meta_reg;
  logic [4:0] pin_sync_reg;
  logic rx_s;
  logic btn_s;
  logic dir_s;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_meta_reg <= sync_conv_pkg::PIN_RESET;
      pin_sync_reg <= sync_conv_pkg::PIN_RESET;
    end else begin
      pin_meta_reg <= {midi_rx, start_button, dir_output, ext_run_in, ext_clk_in};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign rx_s = pin_sync_reg[sync_conv_pkg::PIN_MIDI];
  assign btn_s = pin_sync_reg[sync_conv_pkg::PIN_BUTTON];
  assign dir_s = pin_sync_reg[sync_conv_pkg::PIN_DIR];

  ////////////////////////////////////////////////////////////////////////////////
  // MIDI byte receiver

  sync_conv_pkg::rx_state_type rx_state_reg;
  logic [31:0] rx_cnt_reg;
  logic [2:0] rx_bit_reg;
  logic [7:0] rx_shift_reg;
  logic byte_valid_reg;
  logic [7:0] byte_data_reg;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_state_reg <= sync_conv_pkg::RX_IDLE;
      rx_cnt_reg <= '0;
      rx_bit_reg <= '0;
      rx_shift_reg <= '0;
      byte_valid_reg <= 1'b0;
      byte_data_reg <= '0;
    end else begin
      byte_valid_reg <= 1'b0;
      case (rx_state_reg)
        sync_conv_pkg::RX_IDLE: begin
          if (!rx_s) begin
            rx_state_reg <= sync_conv_pkg::RX_START;
            rx_cnt_reg <= sync_conv_pkg::HALF_BIT_CYCLES - 1;
          end
        end
        sync_conv_pkg::RX_START: begin
          if (rx_cnt_reg != 0) begin
            rx_cnt_reg <= rx_cnt_reg - 1;
          end else if (!rx_s) begin
            rx_state_reg <= sync_conv_pkg::RX_DATA;
            rx_cnt_reg <= sync_conv_pkg::BIT_CYCLES - 1;
            rx_bit_reg <= '0;
          end else begin
            // Glitch, not a start bit
            rx_state_reg <= sync_conv_pkg::RX_IDLE;
          end
        end
        sync_conv_pkg::RX_DATA: begin
          if (rx_cnt_reg != 0) begin
            rx_cnt_reg <= rx_cnt_reg - 1;
          end else begin
            rx_shift_reg <= {rx_s, rx_shift_reg[7:1]};
            rx_cnt_reg <= sync_conv_pkg::BIT_CYCLES - 1;
            if (rx_bit_reg == 3'h7) begin
              rx_state_reg <= sync_conv_pkg::RX_STOP;
            end else begin
              rx_bit_reg <= rx_bit_reg + 3'h1;
            end
          end
        end
        sync_conv_pkg::RX_STOP: begin
          if (rx_cnt_reg != 0) begin
            rx_cnt_reg <= rx_cnt_reg - 1;
          end else begin
            rx_state_reg <= sync_conv_pkg::RX_IDLE;
            // Framing errors are dropped silently
            if (rx_s) begin
              byte_valid_reg <= 1'b1;
              byte_data_reg <= rx_shift_reg;
            end
          end
        end
        default: begin
          rx_state_reg <= sync_conv_pkg::RX_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Real-time message decode

  function automatic logic is_sync_byte(input logic [7:0] b);
    is_sync_byte = (b == sync_conv_pkg::MSG_CLOCK) || (b == sync_conv_pkg::MSG_START)
      || (b == sync_conv_pkg::MSG_CONTINUE) || (b == sync_conv_pkg::MSG_STOP);
  endfunction

  // Only single-byte real-time codes are acted on, so interleaving is harmless
  logic clk_byte;
  logic start_byte;
  logic stop_byte;
  logic sync_byte;

  assign clk_byte = byte_valid_reg && (byte_data_reg == sync_conv_pkg::MSG_CLOCK);
  assign start_byte = byte_valid_reg && ((byte_data_reg == sync_conv_pkg::MSG_START)
    || (byte_data_reg == sync_conv_pkg::MSG_CONTINUE));
  assign stop_byte = byte_valid_reg && (byte_data_reg == sync_conv_pkg::MSG_STOP);
  assign sync_byte = byte_valid_reg && is_sync_byte(byte_data_reg);

  ////////////////////////////////////////////////////////////////////////////////
  // MIDI run gate and first-clock holdoff

  logic midi_run_reg;
  logic [31:0] holdoff_cnt_reg;

  // No enable exists on purpose; the converter always runs
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      midi_run_reg <= 1'b0;
    end else if (start_byte) begin
      midi_run_reg <= 1'b1;
    end else if (stop_byte) begin
      midi_run_reg <= 1'b0;
    end
  end

  // Slaves miss a clock edge too close to run rising
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      holdoff_cnt_reg <= '0;
    end else if (start_byte && !midi_run_reg) begin
      holdoff_cnt_reg <= HOLDOFF_CYCLES;
    end else if (holdoff_cnt_reg != 0) begin
      holdoff_cnt_reg <= holdoff_cnt_reg - 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // MIDI clock pulse generator

  logic [PEND_W-1:0] pend_cnt_reg;
  logic pulse_busy_reg;
  logic midi_clk_reg;
  logic [31:0] pulse_cnt_reg;
  logic pulse_start;

  assign pulse_start = !pulse_busy_reg && (pend_cnt_reg != 0) && (holdoff_cnt_reg == 0);

  // Bytes arriving during holdoff or a pulse wait here, up to 15 pending; further ones are dropped
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pend_cnt_reg <= '0;
    end else if (clk_byte && !pulse_start && !(&pend_cnt_reg)) begin
      pend_cnt_reg <= pend_cnt_reg + 1'b1;
    end else if (!clk_byte && pulse_start) begin
      pend_cnt_reg <= pend_cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pulse_busy_reg <= 1'b0;
      midi_clk_reg <= 1'b0;
      pulse_cnt_reg <= '0;
    end else if (pulse_start) begin
      pulse_busy_reg <= 1'b1;
      midi_clk_reg <= 1'b1;
      pulse_cnt_reg <= PULSE_HIGH_CYCLES - 1;
    end else if (pulse_busy_reg) begin
      if (pulse_cnt_reg != 0) begin
        pulse_cnt_reg <= pulse_cnt_reg - 1;
      end else if (midi_clk_reg) begin
        midi_clk_reg <= 1'b0;
        pulse_cnt_reg <= PULSE_LOW_CYCLES - 1;
      end else begin
        pulse_busy_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Tempo oscillator inhibit

  logic inhibit_reg;
  logic [31:0] inhibit_cnt_reg;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      inhibit_reg <= 1'b0;
      inhibit_cnt_reg <= '0;
    end else if (sync_byte) begin
      inhibit_reg <= 1'b1;
      inhibit_cnt_reg <= INHIBIT_CYCLES - 1;
    end else if (inhibit_cnt_reg != 0) begin
      inhibit_cnt_reg <= inhibit_cnt_reg - 1;
    end else begin
      inhibit_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Internal tempo system

  logic btn_prev_reg;
  logic btn_rise;
  logic int_run_reg;
  logic [31:0] restart_cnt_reg;
  logic [23:0] osc_cnt_reg;
  logic int_clk_reg;
  logic osc_enable;

  // No debounce: the button is assumed clean
  assign btn_rise = btn_s && !btn_prev_reg && dir_s;
  assign osc_enable = !inhibit_reg && (restart_cnt_reg == 0) && dir_s;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      btn_prev_reg <= 1'b0;
      int_run_reg <= 1'b0;
    end else begin
      btn_prev_reg <= btn_s;
      if (btn_rise) begin
        int_run_reg <= !int_run_reg;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      restart_cnt_reg <= '0;
    end else if (btn_rise && !int_run_reg) begin
      restart_cnt_reg <= RESTART_CYCLES;
    end else if (restart_cnt_reg != 0) begin
      restart_cnt_reg <= restart_cnt_reg - 1;
    end
  end

  // Halting preloads a full low half, so no clock edge follows a restart at once
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      osc_cnt_reg <= '0;
      int_clk_reg <= 1'b0;
    end else if (!osc_enable) begin
      osc_cnt_reg <= tempo_half_period - 24'h00_0001;
      int_clk_reg <= 1'b0;
    end else if (osc_cnt_reg == 24'h00_0000) begin
      osc_cnt_reg <= tempo_half_period - 24'h00_0001;
      int_clk_reg <= !int_clk_reg;
    end else begin
      osc_cnt_reg <= osc_cnt_reg - 24'h00_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Merge and sync switch

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sock_run_o <= 1'b0;
      sock_clk_o <= 1'b0;
      sock_run_oe <= 1'b0;
      sock_clk_oe <= 1'b0;
      seq_run <= 1'b0;
      seq_clk <= 1'b0;
    end else begin
      sock_run_o <= midi_run_reg || int_run_reg;
      sock_clk_o <= midi_clk_reg || int_clk_reg;
      sock_run_oe <= dir_s;
      sock_clk_oe <= dir_s;
      if (dir_s) begin
        seq_run <= midi_run_reg || int_run_reg;
        seq_clk <= midi_clk_reg || int_clk_reg;
      end else begin
        seq_run <= pin_sync_reg[sync_conv_pkg::PIN_EXT_RUN];
        seq_clk <= pin_sync_reg[sync_conv_pkg::PIN_EXT_CLK];
      end
    end
  end

  assign osc_inhibit = inhibit_reg;
  assign int_run = int_run_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_pulse_rise;
    !midi_clk_reg ##1 midi_clk_reg;
  endsequence

  sequence s_pulse_hold;
    midi_clk_reg [*8];
  endsequence

  chk_run_on_start: assert property (start_byte |=> midi_run_reg)
    else $error("run gate not raised by start");
  chk_run_off_stop: assert property (stop_byte |=> !midi_run_reg)
    else $error("run gate not dropped by stop");
  chk_run_holds: assert property (midi_run_reg && !stop_byte |=> midi_run_reg)
    else $error("run gate fell without stop");
  chk_holdoff_load: assert property ($rose(midi_run_reg) |-> holdoff_cnt_reg == HOLDOFF_CYCLES)
    else $error("holdoff not loaded on run rise");
  chk_holdoff_block: assert property (holdoff_cnt_reg != 0 |=> !$rose(midi_clk_reg))
    else $error("clock pulse started during holdoff");
  chk_pulse_shape: assert property (s_pulse_rise |-> s_pulse_hold)
    else $error("sync clock pulse too short");
  chk_pend_count: assert property (clk_byte && !pulse_start && pend_cnt_reg == 0
    |=> pend_cnt_reg == 1)
    else $error("clock byte not counted");
  chk_inhibit_set: assert property (sync_byte |=> osc_inhibit ##1 osc_inhibit)
    else $error("inhibit not raised by sync byte");
  chk_inhibit_stops: assert property (osc_inhibit |=> !int_clk_reg)
    else $error("oscillator ran while inhibited");
  chk_button_toggle: assert property (btn_rise |=> int_run_reg != $past(int_run_reg))
    else $error("button did not toggle run");
  chk_restart_halt: assert property ($rose(int_run_reg) |-> restart_cnt_reg != 0 && !int_clk_reg)
    else $error("oscillator not halted on start");
  chk_merge_out: assert property (dir_s |=> sock_run_o == ($past(midi_run_reg) || $past(int_run_reg))
    && sock_clk_o == ($past(midi_clk_reg) || $past(int_clk_reg)))
    else $error("merged outputs wrong");
  chk_input_mode: assert property (!dir_s |=> !sock_run_oe && !sock_clk_oe)
    else $error("socket driven in input mode");

endmodule
`default_nettype wire

// ==== tb/midi_master_model.sv ====
// Behavioural MIDI master that sends 8N1 bytes onto the serial line
`default_nettype none
module midi_master_model (
  output logic midi_rx, // Serial line into the converter, idle high
  input wire logic sys_clk // Bench clock, bit timing counted on it
);
  timeunit 1ns;
  timeprecision 1ps;

  initial midi_rx = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // Leading idle bit doubles as the stop bit of the byte before, so the task
  // returns as the stop bit begins and the caller can watch the effect
  task automatic send_byte(input logic [7:0] data);
    logic [9:0] frame;
    frame = {data, 1'b0, 1'b1};
    for (int i = 0; i < 10; i++) begin
      @(negedge sys_clk);
      midi_rx = frame[i];
      repeat (sync_conv_pkg::BIT_CYCLES - 1) @(negedge sys_clk);
    end
    @(negedge sys_clk);
    midi_rx = 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== tb/midi_to_din_sync_converter_tb_top.sv ====
// Self-checking bench for the MIDI to DIN sync converter
`default_nettype none
module midi_to_din_sync_converter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // Short counts keep the run near the cycle budget; a MIDI byte alone is 32000
  localparam int HOLD = 36000;
  localparam int RESTART = 50;
  localparam int INHIB = 500;
  localparam int PH = 10;
  localparam int PL = 10;

  logic sys_clk, rst, midi_rx, start_button, dir_output, ext_run_in, ext_clk_in;
  logic [23:0] tempo_half_period;
  logic sock_run_o, sock_run_oe, sock_clk_o, sock_clk_oe;
  logic seq_run, seq_clk, osc_inhibit, int_run;
  int miscompares = 0;
  int checks = 0;

  midi_master_model u_midi_master_model (.midi_rx(midi_rx), .sys_clk(sys_clk));

  midi_to_din_sync_converter #(
    .HOLDOFF_CYCLES(HOLD), .RESTART_CYCLES(RESTART), .INHIBIT_CYCLES(INHIB),
    .PULSE_HIGH_CYCLES(PH), .PULSE_LOW_CYCLES(PL), .PEND_W(4)
  ) u_midi_to_din_sync_converter (
    .sys_clk(sys_clk), .rst(rst), .midi_rx(midi_rx), .start_button(start_button),
    .dir_output(dir_output), .tempo_half_period(tempo_half_period),
    .ext_run_in(ext_run_in), .ext_clk_in(ext_clk_in), .sock_run_o(sock_run_o),
    .sock_run_oe(sock_run_oe), .sock_clk_o(sock_clk_o), .sock_clk_oe(sock_clk_oe),
    .seq_run(seq_run), .seq_clk(seq_clk), .osc_inhibit(osc_inhibit), .int_run(int_run)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check_bit(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic check_count(input int got, input int lo, input int hi, input string what);
    checks++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("mismatch at %0t: %s took %0d cycles, not %0d..%0d", $time, what, got, lo, hi);
    end
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: pick = seq_clk;
      1: pick = seq_run;
      2: pick = osc_inhibit;
      default: pick = int_run;
    endcase
  endfunction

  // Counts falling edges until the level shows; running out ends the run
  task automatic wait_for(input int sel, input logic val, input int bound, output int n);
    n = 0;
    while (pick(sel) !== val) begin
      if (n >= bound) begin
        miscompares++;
        $display("mismatch at %0t: wait on output %0d ran out", $time, sel);
        tally_and_finish();
      end
      @(negedge sys_clk);
      n++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_clock_only();
    int n;
    logic extra;
    extra = 1'b0;
    u_midi_master_model.send_byte(sync_conv_pkg::MSG_CLOCK);
    wait_for(0, 1'b1, 2000, n);
    check_bit(seq_run, 1'b0, "run while clocks only");
    check_bit(osc_inhibit, 1'b1, "inhibit on clock byte");
    check_bit(sock_clk_o & sock_clk_oe, 1'b1, "socket clock");
    wait_for(0, 1'b0, PH + 5, n);
    check_count(n, PH, PH, "pulse high");
    repeat (PL + 40) begin
      @(negedge sys_clk);
      if (seq_clk !== 1'b0) extra = 1'b1;
    end
    check_bit(extra, 1'b0, "second pulse for one byte");
    $display("test clock_only done");
  endtask

  task automatic test_continue_holdoff();
    int n;
    u_midi_master_model.send_byte(sync_conv_pkg::MSG_CONTINUE);
    wait_for(1, 1'b1, 2000, n);
    check_bit(sock_run_o & sock_run_oe, 1'b1, "socket run");
    fork
      u_midi_master_model.send_byte(sync_conv_pkg::MSG_CLOCK);
      begin
        wait_for(0, 1'b1, HOLD + 100, n);
        check_count(n, HOLD, HOLD + 4, "first clock after run");
        check_bit(seq_run, 1'b1, "run held during play");
      end
    join
    $display("test continue_holdoff done");
  endtask

  task automatic test_stop_inhibit();
    int n;
    u_midi_master_model.send_byte(sync_conv_pkg::MSG_STOP);
    wait_for(1, 1'b0, 2000, n);
    check_bit(osc_inhibit, 1'b1, "inhibit on stop byte");
    wait_for(2, 1'b0, INHIB + 50, n);
    check_count(n, INHIB - 5, INHIB + 5, "inhibit hold");
    $display("test stop_inhibit done");
  endtask

  task automatic press();
    @(negedge sys_clk);
    start_button = 1'b1;
    repeat (6) @(negedge sys_clk);
    start_button = 1'b0;
    repeat (6) @(negedge sys_clk);
  endtask

  task automatic test_button_and_input();
    int n;
    tempo_half_period = 24'h00_0014;
    press();
    check_bit(int_run, 1'b1, "run flip-flop on");
    check_bit(seq_run & sock_run_o, 1'b1, "ored run");
    wait_for(0, 1'b1, RESTART + 60, n);
    check_count(n, RESTART - 12, RESTART + 30, "oscillator restart");
    wait_for(0, 1'b0, 40, n);
    check_count(n, 19, 21, "oscillator high");
    wait_for(0, 1'b1, 40, n);
    check_count(n, 19, 21, "oscillator low");
    dir_output = 1'b0;
    ext_run_in = 1'b0;
    ext_clk_in = 1'b1;
    repeat (5) @(negedge sys_clk);
    check_bit(sock_run_oe | sock_clk_oe, 1'b0, "pins released");
    check_bit(seq_run, 1'b0, "run from pin");
    check_bit(seq_clk, 1'b1, "clock from pin");
    ext_run_in = 1'b1;
    ext_clk_in = 1'b0;
    press();
    check_bit(int_run, 1'b1, "button ignored on input");
    check_bit(seq_run, 1'b1, "run from pin high");
    check_bit(seq_clk, 1'b0, "clock from pin low");
    dir_output = 1'b1;
    repeat (5) @(negedge sys_clk);
    press();
    check_bit(int_run, 1'b0, "run flip-flop off");
    check_bit(seq_run, 1'b0, "ored run low");
    $display("test button_and_input done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    start_button = 1'b0;
    dir_output = 1'b1;
    ext_run_in = 1'b0;
    ext_clk_in = 1'b0;
    // Huge half period keeps the oscillator low while MIDI pulses are judged
    tempo_half_period = 24'hFF_FFFF;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    test_clock_only();
    test_continue_holdoff();
    test_stop_inhibit();
    test_button_and_input();
    tally_and_finish();
  end
endmodule
`default_nettype wire
